// ### logic/fsps_pkg.sv
package fsps_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_OPSEL = 8'h04;
    localparam logic [7:0] OFF_ADDR_HI = 8'h08;
    localparam logic [7:0] OFF_ADDR_LO = 8'h0C;
    localparam logic [7:0] OFF_DATA = 8'h10;
    localparam logic [7:0] OFF_UNLOCK = 8'h14;
    localparam logic [7:0] OFF_LOWBOUND = 8'h18;
    localparam logic [7:0] OFF_CLKCON = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // Field positions.
    localparam int CTRL_EN_BIT = 7;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_IGN_BIT = 1;
    localparam int STAT_BOOTEXEC_BIT = 2;
    // Reset values.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [2:0] RST_OPSEL = 3'h0;
    localparam logic [5:0] RST_PRESCALE = 6'h00;
    // Unlock bytes.
    localparam logic [7:0] UNLOCK_FIRST = 8'h46;
    localparam logic [7:0] UNLOCK_SECOND = 8'hB9;
    // Flash geometry: 32K bytes, 512-byte pages, boot region in 0.5KB steps.
    localparam int FLASH_BYTES = 32768;
    localparam int PAGE_BYTES = 512;
    localparam int BOOT_STEP_BYTES = 512;
    localparam int BOOT_MAX_STEPS = 15;
    localparam logic [14:0] FLASH_LAST = 15'h7FFF;
    // Cycles a program or erase step holds the CPU, scaled by prescaler + 1.
    localparam int OP_BASE_CYCLES = 4;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        FSPS_OP_STANDBY = 3'b000,
        FSPS_OP_READ = 3'b001,
        FSPS_OP_PROGRAM = 3'b010,
        FSPS_OP_ERASE = 3'b011
    } fsps_op_e;

    typedef enum logic [1:0] {
        FSPS_ST_IDLE = 2'b00,
        FSPS_ST_WAIT = 2'b01,
        FSPS_ST_ERASE = 2'b10,
        FSPS_ST_DONE = 2'b11
    } fsps_state_e;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
        fsps_op_e op;
    } fsps_req_s;
endpackage

// ### logic/fsps_sequencer.sv
// Functional notes
// R01 - Boot-region code may erase and program application and data regions.
// R02 - Application code may modify only the data region.
// R03 - Boot region size set by hardware option, 0 to 7.5K in 0.5KB steps.
// R04 - Data region spans low-bound register up to boot region start.
// R05 - Low-bound register loads from hardware option; software may rewrite it.
// R06 - Select field: 011 page erase, 010 byte program, 001 byte read.
// R07 - Operation starts only after 0x46 then 0xB9 written to unlock register.
// R08 - Byte program writes data register byte to high/low address.
// R09 - Byte read places addressed flash byte into data register.
// R10 - Programming only clears bits; setting bits needs erase.
// R11 - Page erase sets all 512 bytes of one page to ones.
// R12 - Software loads page-aligned address for erase, bits 8..0 zero.
// R13 - CPU stalled from trigger until operation fully completes.
// R14 - Control bit 7 enables self-programming; clear disables it.
// R15 - Software loads timing prescaler before any operation.
// R16 - Software should verify by byte read after program or erase.
// R17 - Trigger with target past last data-region byte is ignored.
// R18 - Interrupts queue during stall; serviced after if still pending.
// R19 - Any wrong unlock write aborts the sequence.
// R20 - Enable clear or standby select: unlock starts no operation.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module fsps_sequencer
    import fsps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] boot_size_opt,
    input wire logic [14:0] low_bound_opt,
    input wire logic exec_in_boot,
    output logic cpu_stall,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [7:0] flash_mem [FLASH_BYTES];
    logic [7:0] flash_control_reg_ff;
    logic [2:0] operation_select_field_ff;
    logic [6:0] flash_address_high_reg_ff;
    logic [7:0] flash_address_low_reg_ff;
    logic [7:0] flash_data_reg_ff;
    logic [14:0] data_region_low_bound_reg_ff;
    logic [5:0] flash_timing_prescaler_field_ff;
    logic unlock_armed_ff;
    logic ignored_ff;
    fsps_state_e state_ff;
    fsps_req_s req_ff;
    logic [12:0] wait_cnt_ff;
    logic [8:0] erase_idx_ff;
    logic [7:0] aw_addr_ff;
    logic aw_have_ff;
    logic [7:0] w_data_ff;
    logic w_have_ff;
    logic w_lane0_ff;
    logic [1:0] bresp_ff;
    logic bvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic rvalid_ff;
    logic boot_size_latched;
    logic [3:0] boot_size_ff;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic trigger;
    logic [14:0] tgt_addr;
    logic [15:0] boot_start;
    logic target_ok;
    logic [12:0] op_cycles;

    // Boot start is 16 bits wide so that a disabled boot region leaves the whole flash below it.
    assign boot_start = 16'(FLASH_BYTES - int'(boot_size_ff) * BOOT_STEP_BYTES); // R03
    assign tgt_addr = {flash_address_high_reg_ff, flash_address_low_reg_ff};

    always_comb begin
        target_ok = 1'b0;
        if ({1'b0, req_ff.addr} < boot_start) begin
            if (exec_in_boot) begin
                target_ok = 1'b1; // R01
            end else begin
                target_ok = (req_ff.addr >= data_region_low_bound_reg_ff); // R02 R04
            end
        end
        // Erase covers the whole page, so the page base must also be in range.
        if (req_ff.op == FSPS_OP_ERASE && !exec_in_boot
                && {req_ff.addr[14:9], 9'h000} < data_region_low_bound_reg_ff) begin
            target_ok = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_size_latched <= 1'b0;
            boot_size_ff <= 4'h0;
        end else if (!boot_size_latched) begin
            boot_size_latched <= 1'b1;
            boot_size_ff <= (boot_size_opt > 4'(BOOT_MAX_STEPS)) ? 4'(BOOT_MAX_STEPS) : boot_size_opt; // R03
        end
    end

    // AXI write channel: address and data may arrive in either order.
    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready = !w_have_ff && !bvalid_ff;
    assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_addr = aw_addr_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 8'h00;
            w_lane0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata[7:0];
                w_lane0_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_addr <= OFF_STATUS && wr_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Register writes; only byte lane 0 carries register contents.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flash_control_reg_ff <= RST_CTRL;
            operation_select_field_ff <= RST_OPSEL;
            flash_address_high_reg_ff <= 7'h00;
            flash_address_low_reg_ff <= 8'h00;
            flash_timing_prescaler_field_ff <= RST_PRESCALE;
        end else if (wr_fire && w_lane0_ff) begin
            case (wr_addr)
                OFF_CTRL: flash_control_reg_ff <= w_data_ff; // R14
                OFF_OPSEL: operation_select_field_ff <= w_data_ff[2:0]; // R06
                OFF_ADDR_HI: flash_address_high_reg_ff <= w_data_ff[6:0];
                OFF_ADDR_LO: flash_address_low_reg_ff <= w_data_ff;
                OFF_CLKCON: flash_timing_prescaler_field_ff <= w_data_ff[5:0];
                default: begin
                end
            endcase
        end
    end

    // Low bound loads from its option one cycle after reset release.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_region_low_bound_reg_ff <= FLASH_LAST;
        end else if (!boot_size_latched) begin
            data_region_low_bound_reg_ff <= low_bound_opt; // R05
        end else if (wr_fire && w_lane0_ff && wr_addr == OFF_LOWBOUND) begin
            data_region_low_bound_reg_ff <= {w_data_ff[6:0], 8'h00}; // R05
        end
    end

    // Unlock sequencer.
    assign trigger = wr_fire && w_lane0_ff && wr_addr == OFF_UNLOCK && unlock_armed_ff
        && w_data_ff == UNLOCK_SECOND; // R07

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            unlock_armed_ff <= 1'b0;
        end else if (wr_fire && wr_addr == OFF_UNLOCK) begin
            unlock_armed_ff <= w_lane0_ff && !unlock_armed_ff && w_data_ff == UNLOCK_FIRST; // R07 R19
        end
    end

    assign op_cycles = 13'(OP_BASE_CYCLES * (int'(flash_timing_prescaler_field_ff) + 1));

    // Flash engine; the CPU is held for the whole operation.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= FSPS_ST_IDLE;
            req_ff <= '{addr: 15'h0000, data: 8'h00, op: FSPS_OP_STANDBY};
            wait_cnt_ff <= 13'h0000;
            erase_idx_ff <= 9'h000;
        end else begin
            case (state_ff)
                FSPS_ST_IDLE: begin
                    if (trigger && flash_control_reg_ff[CTRL_EN_BIT]
                            && operation_select_field_ff inside {FSPS_OP_READ, FSPS_OP_PROGRAM, FSPS_OP_ERASE}) begin // R20
                        state_ff <= FSPS_ST_WAIT;
                        req_ff <= '{addr: tgt_addr, data: flash_data_reg_ff, op: fsps_op_e'(operation_select_field_ff)};
                        wait_cnt_ff <= op_cycles;
                        erase_idx_ff <= 9'h000;
                    end
                end
                FSPS_ST_WAIT: begin
                    if (wait_cnt_ff > 13'h0001) begin
                        wait_cnt_ff <= wait_cnt_ff - 13'h0001;
                    end else if (req_ff.op == FSPS_OP_ERASE && target_ok) begin
                        state_ff <= FSPS_ST_ERASE;
                    end else begin
                        state_ff <= FSPS_ST_DONE;
                    end
                end
                FSPS_ST_ERASE: begin
                    erase_idx_ff <= erase_idx_ff + 9'h001;
                    if (erase_idx_ff == 9'(PAGE_BYTES - 1)) begin
                        state_ff <= FSPS_ST_DONE; // R11
                    end
                end
                FSPS_ST_DONE: state_ff <= FSPS_ST_IDLE;
                default: state_ff <= FSPS_ST_IDLE;
            endcase
        end
    end

    // Flash array. Erase addresses the page base whatever the low address bits.
    always_ff @(posedge sys_clk) begin
        if (state_ff == FSPS_ST_ERASE) begin
            flash_mem[{req_ff.addr[14:9], erase_idx_ff}] <= 8'hFF; // R11
        end else if (state_ff == FSPS_ST_DONE && req_ff.op == FSPS_OP_PROGRAM && target_ok) begin
            flash_mem[req_ff.addr] <= flash_mem[req_ff.addr] & req_ff.data; // R08 R10 R17
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ignored_ff <= 1'b0;
        end else if (state_ff == FSPS_ST_WAIT && wait_cnt_ff <= 13'h0001) begin
            ignored_ff <= !target_ok; // R17
        end
    end

    // Data register: software writes, or the result of a read operation.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flash_data_reg_ff <= 8'h00;
        end else if (state_ff == FSPS_ST_DONE && req_ff.op == FSPS_OP_READ && target_ok) begin
            flash_data_reg_ff <= flash_mem[req_ff.addr]; // R09
        end else if (wr_fire && w_lane0_ff && wr_addr == OFF_DATA) begin
            flash_data_reg_ff <= w_data_ff;
        end
    end

    // Interrupt requests stay pending in the interrupt controller while stalled.
    assign cpu_stall = (state_ff != FSPS_ST_IDLE); // R13 R18

    // AXI read channel.
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (s_axi_araddr[7:0])
                OFF_CTRL: rdata_ff <= {24'h00_0000, flash_control_reg_ff};
                OFF_OPSEL: rdata_ff <= {29'h0000_0000, operation_select_field_ff};
                OFF_ADDR_HI: rdata_ff <= {25'h000_0000, flash_address_high_reg_ff};
                OFF_ADDR_LO: rdata_ff <= {24'h00_0000, flash_address_low_reg_ff};
                OFF_DATA: rdata_ff <= {24'h00_0000, flash_data_reg_ff};
                OFF_UNLOCK: rdata_ff <= 32'h0000_0000;
                OFF_LOWBOUND: rdata_ff <= {24'h00_0000, 1'b0, data_region_low_bound_reg_ff[14:8]};
                OFF_CLKCON: rdata_ff <= {26'h000_0000, flash_timing_prescaler_field_ff};
                OFF_STATUS: rdata_ff <= {29'h0000_0000, exec_in_boot, ignored_ff, cpu_stall};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule // fsps_sequencer
`default_nettype wire

// ### dv/fsps_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module fsps_assertions
    import fsps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cpu_stall,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_idle_after_reset: assert property ($fell(rst) |-> !cpu_stall && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active right after reset");
    chk_write_answer_time: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |-> ##2 s_axi_bvalid) else $error("write response late or missing");
    chk_write_refused_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
    chk_write_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    chk_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late or address still accepted");
    chk_read_resp_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    chk_stall_with_trigger: assert property ($rose(cpu_stall) |-> $rose(s_axi_bvalid))
        else $error("stall began without a completed unlock write");
    chk_stall_min_len: assert property ($rose(cpu_stall) |-> cpu_stall[*5])
        else $error("stall shorter than one wait step plus done cycle");
    chk_stall_max_len: assert property ($rose(cpu_stall) |-> ##[1:769] !cpu_stall)
        else $error("stall exceeds longest operation");
    cover property ($rose(cpu_stall));
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule // fsps_assertions

bind fsps_sequencer fsps_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .cpu_stall(cpu_stall),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ### dv/fsps_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fsps_sequencer_test
    import fsps_pkg::*;
;
    localparam int BOOT_SZ = 3;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic exec_in_boot = 1'b0;
    logic cpu_stall;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [14:0] lb = 15'h7600;
    logic [14:0] a;
    logic [7:0] d;
    logic [5:0] pre;
    logic [7:0] shadow [int];
    int err_count = 0, n_compared = 0, n_stall = 0, cur_len = 0, last_len = 0;

    fsps_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .boot_size_opt(4'(BOOT_SZ)), .low_bound_opt(15'h7600),
        .exec_in_boot(exec_in_boot), .cpu_stall(cpu_stall), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // Stall episodes are counted and timed here so that every trigger, wanted or not, is seen.
    always @(posedge sys_clk) begin
        if (cpu_stall) begin
            if (cur_len == 0) n_stall++;
            cur_len++;
        end else if (cur_len != 0) begin
            last_len = cur_len;
            cur_len = 0;
        end
    end

    task automatic conclude;
        $display("mismatches %0d, comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dat, input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge sys_clk);
        s_axi_awaddr <= {24'h00_0000, ad};
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n > 300) begin
                err_count++;
                conclude();
            end
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] dat, input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge sys_clk);
        s_axi_araddr <= {24'h00_0000, ad};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n > 300) begin
                err_count++;
                conclude();
            end
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        dat = s_axi_rdata;
        `CHK(s_axi_rresp, er)
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] v;
        rd(ad, v);
        `CHK(v, exp)
    endtask

    task automatic no_op(input logic [7:0] first);
        int n0;
        n0 = n_stall;
        wr(OFF_UNLOCK, {24'h00_0000, first});
        wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_SECOND});
        repeat (3) @(posedge sys_clk);
        `CHK(n_stall, n0)
    endtask

    task automatic op_chk(input logic [2:0] op, input logic [14:0] ad, input logic [7:0] dat);
        int n0;
        int n;
        logic ok;
        logic [14:0] b;
        logic [31:0] v;
        b = (op == FSPS_OP_ERASE) ? {ad[14:9], 9'h000} : ad;
        ok = (int'(b) < FLASH_BYTES - BOOT_STEP_BYTES * BOOT_SZ) && (exec_in_boot || b >= lb);
        wr(OFF_OPSEL, {29'h0, op});
        wr(OFF_ADDR_HI, {25'h000_0000, b[14:8]});
        wr(OFF_ADDR_LO, {24'h00_0000, b[7:0]});
        wr(OFF_DATA, {24'h00_0000, dat});
        n0 = n_stall;
        wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_FIRST});
        wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_SECOND});
        n = 0;
        while (cpu_stall && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        if (cpu_stall) begin
            err_count++;
            conclude();
        end
        @(posedge sys_clk);
        `CHK(n_stall, n0 + 1)
        `CHK(last_len, OP_BASE_CYCLES * (int'(pre) + 1) + 1 + ((op == FSPS_OP_ERASE && ok) ? PAGE_BYTES : 0))
        rd(OFF_STATUS, v);
        `CHK(v[STAT_IGN_BIT], !ok)
        if (ok && op == FSPS_OP_ERASE) for (int i = 0; i < PAGE_BYTES; i++) shadow[int'(b) + i] = 8'hFF;
        if (ok && op == FSPS_OP_PROGRAM) shadow[int'(ad)] = shadow[int'(ad)] & dat;
        if (ok && op == FSPS_OP_READ) begin
            rd(OFF_DATA, v);
            `CHK(v[7:0], shadow[int'(ad)])
        end
    endtask

    initial begin
        void'($urandom(554));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rdchk(OFF_CTRL, {24'h00_0000, RST_CTRL});
        rdchk(OFF_OPSEL, {29'h0, RST_OPSEL});
        rdchk(OFF_CLKCON, {26'h000_0000, RST_PRESCALE});
        rdchk(OFF_LOWBOUND, 32'h0000_0076);
        wr(8'h24, 32'h0000_0001, RESP_SLVERR);
        rd(8'h24, rv, RESP_SLVERR);
        pre = 6'($urandom_range(3, 0));
        wr(OFF_CLKCON, {26'h000_0000, pre});
        wr(OFF_OPSEL, {29'h0, FSPS_OP_PROGRAM});
        no_op(UNLOCK_FIRST);
        wr(OFF_CTRL, 32'h0000_0080);
        wr(OFF_OPSEL, {29'h0, FSPS_OP_STANDBY});
        no_op(UNLOCK_FIRST);
        wr(OFF_OPSEL, {29'h0, FSPS_OP_PROGRAM});
        // With byte lane 0 off a write changes no register and cannot arm the unlock.
        s_axi_wstrb <= 4'h0;
        wr(OFF_CTRL, 32'h0000_0000);
        rdchk(OFF_CTRL, 32'h0000_0080);
        wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_FIRST});
        s_axi_wstrb <= 4'h1;
        no_op(UNLOCK_SECOND);
        wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_FIRST});
        no_op(8'h12);
        a = 15'h7600 + 15'($urandom_range(511, 0));
        d = 8'($urandom);
        op_chk(FSPS_OP_ERASE, 15'h7600, 8'h00);
        op_chk(FSPS_OP_READ, a, 8'h00);
        op_chk(FSPS_OP_PROGRAM, a, d);
        op_chk(FSPS_OP_READ, a, 8'h00);
        op_chk(FSPS_OP_PROGRAM, a, 8'($urandom));
        op_chk(FSPS_OP_READ, a, 8'h00);
        op_chk(FSPS_OP_PROGRAM, 15'h1000, d);
        op_chk(FSPS_OP_READ, 15'h7A10, 8'h00);
        lb = 15'h7800;
        wr(OFF_LOWBOUND, 32'h0000_0078);
        rdchk(OFF_LOWBOUND, 32'h0000_0078);
        op_chk(FSPS_OP_PROGRAM, a, d);
        exec_in_boot <= 1'b1;
        rdchk(OFF_STATUS, 32'h0000_0006);
        op_chk(FSPS_OP_ERASE, 15'h1123, 8'h00);
        op_chk(FSPS_OP_ERASE, 15'h7A00, 8'h00);
        // Random mix inside one boot-writable page keeps the shadow copy exact.
        repeat (8) op_chk(3'($urandom_range(3, 1)), 15'h1000 + 15'($urandom_range(511, 0)), 8'($urandom));
        conclude();
    end
endmodule // fsps_sequencer_test
`default_nettype wire
